/* hdl/host_port_and_error_flag.v */
`include "host_port_consts.vh"

module host_port_and_error_flag #(
    parameter ERR_W = 5
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // video side, word clock domain
    input wire sav_pulse,
    input wire frame_start,
    input wire [ERR_W-1:0] err_detect,
    output wire fifo_load_strobe,
    output wire data_error_n,
    // shared host / test pins
    input wire test_mode_sel,
    input wire cs_tms_pin,
    input wire sclk_tck_pin,
    input wire serial_or_test_in_pin,
    output wire serial_or_test_out_pin,
    // test access port hookup
    input wire tap_tdo,
    output wire tap_tck,
    output wire tap_tms,
    output wire tap_tdi
);

////////////////////////////////////////////////////////////////////////////////
// host frame phases

localparam [2:0] PH_IDLE = 3'h0;
localparam [2:0] PH_CMD = 3'h1;
localparam [2:0] PH_WRITE = 3'h2;
localparam [2:0] PH_READ = 3'h3;
localparam [2:0] PH_DONE = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// registers and their next values

// video side
reg fifo_load_strobe_reg;
reg fifo_load_strobe_next;
reg data_error_n_reg;
reg data_error_n_next;
reg [ERR_W-1:0] fault_record_reg;
wire [ERR_W-1:0] fault_record_next;
wire [ERR_W-1:0] fault_watched;

// host serial port
reg [`WORD_W-1:0] fault_select_reg;
reg [`WORD_W-1:0] fault_select_next;
reg sclk_prev_reg;
reg [2:0] phase_reg;
reg [2:0] phase_next;
reg [5:0] bit_cnt_reg;
reg [5:0] bit_cnt_next;
reg [`WORD_W-1:0] shift_in_reg;
reg [`WORD_W-1:0] shift_in_next;
reg [`WORD_W-1:0] cmd_reg;
reg [`WORD_W-1:0] cmd_next;
reg [`WORD_W-1:0] shift_out_reg;
reg [`WORD_W-1:0] shift_out_next;
reg record_read_reg;
reg record_read_next;

// pin sharing
reg sdout_reg;
reg sdout_next;
reg tck_reg;
reg tck_next;
reg tms_reg;
reg tms_next;
reg tdi_reg;
reg tdi_next;

////////////////////////////////////////////////////////////////////////////////
// decoded pin levels and events

wire host_mode = ~test_mode_sel;
wire host_cs_active = host_mode & ~cs_tms_pin;
wire sclk_rise = sclk_tck_pin & ~sclk_prev_reg;
wire sclk_fall = ~sclk_tck_pin & sclk_prev_reg;
// bits past the end of a frame are ignored until chip select is released
wire take_bit = host_cs_active & sclk_rise & (bit_cnt_reg != `FRAME_BITS);
wire cmd_done = take_bit & (bit_cnt_reg == `CMD_BITS - 6'h01);
wire frame_done = take_bit & (bit_cnt_reg == `FRAME_BITS - 6'h01);
wire out_shift = host_cs_active & sclk_fall & (bit_cnt_reg > `CMD_BITS)
    & cmd_reg[`CMD_READ_BIT];
wire [`WORD_W-1:0] word_in = {shift_in_reg[`WORD_W-2:0], serial_or_test_in_pin};
wire [`CMD_ADDR_MSB:0] cmd_addr_now = word_in[`CMD_ADDR_MSB:0];
wire [`CMD_ADDR_MSB:0] cmd_addr = cmd_reg[`CMD_ADDR_MSB:0];
wire [`WORD_W-1:0] record_word = {{(`WORD_W-ERR_W){1'b0}}, fault_record_reg};
wire record_clear = record_read_reg | frame_start;

////////////////////////////////////////////////////////////////////////////////
// read data chosen at the end of the command word

reg [`WORD_W-1:0] read_word;
always @* begin
    read_word = 16'h0000;
    case (cmd_addr_now)
        `ADDR_FAULT_RECORD: read_word = record_word;
        `ADDR_FAULT_SELECT: read_word = fault_select_reg;
        default: read_word = 16'h0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// fault record, one slice per error condition

genvar gi;
generate
    for (gi = 0; gi < ERR_W; gi = gi + 1) begin : g_err
        // a new error in the clearing cycle is kept: set wins over clear
        assign fault_record_next[gi] = err_detect[gi] | (fault_record_reg[gi] & ~record_clear);
        // masked conditions are still recorded, only kept off the flag
        assign fault_watched[gi] = fault_record_next[gi] & fault_select_reg[gi];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// video side

always @* begin
    fifo_load_strobe_next = ~sav_pulse;
    // or of monitored conditions only, high when clean
    data_error_n_next = ~|fault_watched;
end

always @(posedge clk) begin
    if (!nrst) begin
        fifo_load_strobe_reg <= 1'b1;
        data_error_n_reg <= 1'b1;
        fault_record_reg <= {ERR_W{1'b0}};
    end else begin
        fifo_load_strobe_reg <= fifo_load_strobe_next;
        data_error_n_reg <= data_error_n_next;
        fault_record_reg <= fault_record_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// host frame phase; pins are sampled, so burst clock must stay well below clk/4

always @* begin
    phase_next = phase_reg;
    case (phase_reg)
        PH_IDLE: begin
            phase_next = PH_CMD;
        end
        PH_CMD: begin
            if (cmd_done) begin
                phase_next = word_in[`CMD_READ_BIT] ? PH_READ : PH_WRITE;
            end
        end
        PH_WRITE: begin
            if (frame_done) begin
                phase_next = PH_DONE;
            end
        end
        PH_READ: begin
            if (frame_done) begin
                phase_next = PH_DONE;
            end
        end
        PH_DONE: begin
            phase_next = PH_DONE;
        end
        default: begin
            phase_next = PH_IDLE;
        end
    endcase
    // releasing chip select aborts any frame, even a cut one
    if (!host_cs_active) begin
        phase_next = PH_IDLE;
    end
end

always @* begin
    bit_cnt_next = bit_cnt_reg;
    if (!host_cs_active) begin
        bit_cnt_next = 6'h00;
    end else if (take_bit) begin
        bit_cnt_next = bit_cnt_reg + 6'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// host shift registers

always @* begin
    shift_in_next = shift_in_reg;
    cmd_next = cmd_reg;
    shift_out_next = shift_out_reg;
    record_read_next = 1'b0;
    fault_select_next = fault_select_reg;
    if (take_bit) begin
        shift_in_next = word_in;
        if (cmd_done) begin
            cmd_next = word_in;
            if (word_in[`CMD_READ_BIT]) begin
                // value latched first; the clear a cycle later drops an error first recorded in the latch cycle
                shift_out_next = read_word;
                record_read_next = (cmd_addr_now == `ADDR_FAULT_RECORD);
            end
        end
        if (frame_done && phase_reg == PH_WRITE && cmd_addr == `ADDR_FAULT_SELECT) begin
            fault_select_next = word_in;
        end
    end else if (out_shift) begin
        shift_out_next = {shift_out_reg[`WORD_W-2:0], 1'b0};
    end
end

always @(posedge clk) begin
    if (!nrst) begin
        // unused burst clock is tied high, so start from high
        sclk_prev_reg <= 1'b1;
        phase_reg <= PH_IDLE;
        bit_cnt_reg <= 6'h00;
        shift_in_reg <= 16'h0000;
        cmd_reg <= 16'h0000;
        shift_out_reg <= 16'h0000;
        record_read_reg <= 1'b0;
        fault_select_reg <= `FAULT_SELECT_RESET;
    end else begin
        sclk_prev_reg <= sclk_tck_pin;
        phase_reg <= phase_next;
        bit_cnt_reg <= bit_cnt_next;
        shift_in_reg <= shift_in_next;
        cmd_reg <= cmd_next;
        shift_out_reg <= shift_out_next;
        record_read_reg <= record_read_next;
        fault_select_reg <= fault_select_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin sharing

always @* begin
    if (test_mode_sel) begin
        sdout_next = tap_tdo;
    end else begin
        sdout_next = shift_out_reg[`WORD_W-1];
    end
    // test pins park high in host mode so the port sits idle
    tck_next = test_mode_sel ? sclk_tck_pin : 1'b1;
    tms_next = test_mode_sel ? cs_tms_pin : 1'b1;
    tdi_next = test_mode_sel ? serial_or_test_in_pin : 1'b1;
end

always @(posedge clk) begin
    if (!nrst) begin
        sdout_reg <= 1'b0;
        tck_reg <= 1'b1;
        tms_reg <= 1'b1;
        tdi_reg <= 1'b1;
    end else begin
        sdout_reg <= sdout_next;
        tck_reg <= tck_next;
        tms_reg <= tms_next;
        tdi_reg <= tdi_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs, all straight from flip-flops

assign fifo_load_strobe = fifo_load_strobe_reg;
assign data_error_n = data_error_n_reg;
assign serial_or_test_out_pin = sdout_reg;
assign tap_tck = tck_reg;
assign tap_tms = tms_reg;
assign tap_tdi = tdi_reg;

endmodule

/* hdl/host_port_consts.vh */
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

// host word layout
`define WORD_W 16
`define CMD_READ_BIT 15
`define CMD_ADDR_MSB 11
`define CMD_BITS 6'h10
`define FRAME_BITS 6'h20

// internal register addresses
`define ADDR_FAULT_RECORD 12'h000
`define ADDR_FAULT_SELECT 12'h001

// reset values
`define FAULT_SELECT_RESET 16'hFFFF

`endif

/* tb/host_model.sv */
module host_model (input wire clk, input wire sdo, output logic cs_n = 1,
    output logic sclk = 0, output logic sdi = 1);
    timeunit 1ns;
    timeprecision 1ns;
    // eight word clocks per burst clock keeps the oversampler happy
    task xfer(input logic [31:0] w, output logic [15:0] rd);
        cs_n = 0;
        for (int i = 31; i >= 0; i--) begin
            sdi = w[i];
            sclk = 0;
            repeat (4) @(negedge clk);
            sclk = 1;
            if (i < 16) rd[i] = sdo;
            repeat (4) @(negedge clk);
        end
        sclk = 0;
        repeat (4) @(negedge clk);
        cs_n = 1;
        sdi = ~sdi;
        repeat (4) @(negedge clk);
    endtask
endmodule

/* tb/host_port_and_error_flag_checker.sv */
module host_port_checker #(parameter ERR_W = 5) (input wire clk, input wire nrst,
    input wire sav_pulse, input wire frame_start, input wire [ERR_W-1:0] err_detect,
    input wire fifo_load_strobe, input wire data_error_n, input wire test_mode_sel,
    input wire cs_tms_pin, input wire sclk_tck_pin, input wire serial_or_test_in_pin,
    input wire serial_or_test_out_pin, input wire tap_tdo, input wire tap_tck,
    input wire tap_tms, input wire tap_tdi);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_strobe;
        !fifo_load_strobe ##1 fifo_load_strobe;
    endsequence
    // past values are only trusted once a whole cycle out of reset
    sequence s_tm;
        test_mode_sel && $past(test_mode_sel) && $past(nrst);
    endsequence
    AST_STB_PULSE: assert property (sav_pulse ##1 !sav_pulse |-> s_strobe)
        else $error("strobe pulse");
    AST_STB_IDLE: assert property (!sav_pulse |=> fifo_load_strobe)
        else $error("strobe idle");
    AST_ERR_FALL: assert property ($fell(data_error_n) |-> $past(|err_detect))
        else $error("flag fall");
    AST_ERR_IDLE: assert property (data_error_n && !(|err_detect) |=> data_error_n)
        else $error("flag idle");
    AST_ERR_HOLD: assert property (!data_error_n && !frame_start && cs_tms_pin |=>
        !data_error_n) else $error("flag hold");
    AST_ERR_RISE: assert property ($past(nrst) && $rose(data_error_n) |->
        $past(frame_start) || !cs_tms_pin) else $error("flag rise");
    AST_TAP_IN: assert property (s_tm |-> tap_tck == $past(sclk_tck_pin) &&
        tap_tms == $past(cs_tms_pin) && tap_tdi == $past(serial_or_test_in_pin))
        else $error("tap inputs");
    AST_TAP_OUT: assert property (s_tm |-> serial_or_test_out_pin == $past(tap_tdo))
        else $error("tap out");
    AST_HOST: assert property (!test_mode_sel |=> tap_tck && tap_tms && tap_tdi)
        else $error("tap idle");
endmodule
bind host_port_and_error_flag host_port_checker #(.ERR_W(ERR_W)) i_chk(.clk(clk), .nrst(nrst),
    .sav_pulse(sav_pulse), .frame_start(frame_start), .err_detect(err_detect),
    .fifo_load_strobe(fifo_load_strobe), .data_error_n(data_error_n),
    .test_mode_sel(test_mode_sel), .cs_tms_pin(cs_tms_pin), .sclk_tck_pin(sclk_tck_pin),
    .serial_or_test_in_pin(serial_or_test_in_pin),
    .serial_or_test_out_pin(serial_or_test_out_pin), .tap_tdo(tap_tdo), .tap_tck(tap_tck),
    .tap_tms(tap_tms), .tap_tdi(tap_tdi));

/* tb/tb_host_port_and_error_flag.sv */
module tb_host_port_and_error_flag;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, nrst = 0, sav = 0, fs = 0, tm = 0, tdo = 0;
    logic [4:0] err = 5'h00;
    logic [15:0] rd;
    wire cs, sck, si, so, stb, fl, tck, tms, tdi;
    int err_total = 0, checks_done = 0, cyc = 0;
    host_model i_host(.clk(clk), .sdo(so), .cs_n(cs), .sclk(sck), .sdi(si));
    host_port_and_error_flag i_dut(.clk(clk), .nrst(nrst), .sav_pulse(sav), .frame_start(fs),
        .err_detect(err), .fifo_load_strobe(stb), .data_error_n(fl), .test_mode_sel(tm),
        .cs_tms_pin(cs), .sclk_tck_pin(sck), .serial_or_test_in_pin(si),
        .serial_or_test_out_pin(so), .tap_tdo(tdo), .tap_tck(tck), .tap_tms(tms), .tap_tdi(tdi));
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc == 5000) begin err_total++; end_sim(); end
    task tick(int n); repeat (n) @(negedge clk); endtask
    task chk(logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task perr(logic [4:0] e); err = e; tick(1); err = 5'h00; endtask
    task end_sim;
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_strobe;
        sav = 1;
        tick(1);
        sav = 0;
        chk(stb, 0);
        tick(1);
        chk(stb, 1);
        $display("strobe test end");
    endtask
    task t_flag;
        perr(5'h04);
        chk(fl, 0);
        tick(4);
        chk(fl, 0);
        fs = 1;
        tick(1);
        fs = 0;
        tick(1);
        chk(fl, 1);
        $display("flag test end");
    endtask
    task t_read;
        perr(5'h04);
        i_host.xfer(32'h80000000, rd);
        chk(rd, 16'h0004);
        chk(fl, 1);
        $display("read test end");
    endtask
    task t_mask;
        i_host.xfer(32'h0001001E, rd);
        i_host.xfer(32'h80010000, rd);
        chk(rd, 16'h001E);
        perr(5'h01);
        tick(1);
        chk(fl, 1);
        perr(5'h02);
        chk(fl, 0);
        $display("mask test end");
    endtask
    task t_tap;
        tm = 1;
        for (int v = 0; v < 16; v += 5) begin
            {i_host.cs_n, i_host.sclk, i_host.sdi, tdo} = v[3:0];
            tick(2);
            chk({tms, tck, tdi, so}, v[3:0]);
        end
        tm = 0;
        {i_host.cs_n, i_host.sclk} = 2'h2;
        tick(2);
        chk({tms, tck, tdi}, 3'h7);
        $display("tap test end");
    endtask
    initial begin
        tick(12);
        nrst = 1;
        tick(1);
        t_strobe();
        t_flag();
        t_read();
        t_mask();
        t_tap();
        end_sim();
    end
endmodule
